// File: logic/snr_cfg.svh
`ifndef SNR_CFG_SVH
`define SNR_CFG_SVH
`define SNR_NLINK 8
`define SNR_ADR_SWDIV 8'h07
`define SNR_ADR_REFDIV 8'h08
`define SNR_ADR_JTAGID 8'h09
`define SNR_ADR_USER 8'h0A
`define SNR_ADR_DIRLO 8'h0C
`define SNR_ADR_DIRHI 8'h0D
`define SNR_ADR_DBG0 8'h10
`define SNR_ADR_DBG1 8'h11
`define SNR_ADR_DBGSRC 8'h1F
`define SNR_ADR_LSTAT 8'h20
`define SNR_ADR_PSTAT 8'h40
`define SNR_ADR_XCFG 8'h80
`define SNR_ADR_STATIC 8'hA0
`define SNR_RST_SWDIV 16'h0000
`define SNR_RST_REFDIV 16'h0003
`define SNR_B_DBG_REQ 1
`define SNR_B_DBG_DRV 0
`define SNR_B_SRC_PIN 4
`define SNR_L_TARGET 24
`define SNR_L_DEST 16
`define SNR_L_DIR 8
`define SNR_L_NET 4
`define SNR_B_JUNK 2
`define SNR_B_DBUSY 1
`define SNR_B_SBUSY 0
`define SNR_B_XEN 31
`define SNR_B_XMODE 30
`define SNR_B_XERR 27
`define SNR_B_CRGIVEN 26
`define SNR_B_CRHELD 25
`define SNR_B_CRRST 24
`define SNR_B_RXRST 23
`define SNR_L_SYMGAP 11
`define SNR_L_TOKGAP 0
`define SNR_B_STEN 31
`define SNR_B_STPROC 8
`define SNR_L_STCHAN 0
`endif

// File: logic/snr_pkg.sv
package snr_pkg;
  typedef logic [3:0] snr_dir_t;
  typedef logic [1:0] snr_net_t;
  typedef logic [10:0] snr_gap_t;
  typedef logic [11:0] snr_gcnt_t;
  typedef logic [4:0] snr_chan_t;
endpackage : snr_pkg

// File: logic/snr_top.sv
`timescale 1ns/100ps
`include "snr_cfg.svh"
module snr_top #(
  parameter logic [31:0] ID_CODE = 32'h1234_5671 // Arbitrary value
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic cfg_req,
  input wire logic cfg_write,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  output logic sw_clk_en,
  output logic ref_clk_en,
  input wire logic [13:0] otp_user_code,
  input wire logic [17:0] metal_id_code,
  input wire logic [15:0] node_id,
  input wire logic route_req,
  input wire logic [15:0] route_dest,
  output logic route_valid,
  output logic [3:0] route_dir,
  input wire logic [1:0] core_halted_flag,
  output logic [1:0] halt_request,
  input wire logic halt_pin_in_n,
  output logic halt_pin_out,
  output logic halt_pin_oe_n,
  output logic shared_halt_line,
  input wire logic [15:0] lnk_target,
  input wire logic [63:0] lnk_dest,
  input wire logic [7:0] lnk_junk,
  input wire logic [7:0] lnk_dst_busy,
  input wire logic [7:0] lnk_src_busy,
  output logic [31:0] lnk_dir,
  output logic [15:0] lnk_net,
  input wire logic [15:0] plk_target,
  input wire logic [63:0] plk_dest,
  input wire logic [7:0] plk_junk,
  input wire logic [7:0] plk_dst_busy,
  input wire logic [7:0] plk_src_busy,
  output logic [15:0] plk_net,
  output logic [7:0] xl_enable,
  output logic [7:0] xl_five_wire,
  input wire logic [7:0] xl_rx_overflow,
  input wire logic [7:0] xl_rx_illegal,
  input wire logic [7:0] xl_credit_given,
  input wire logic [7:0] xl_credit_held,
  output logic [7:0] xl_credit_clear,
  output logic [7:0] xl_hello_req,
  output logic [7:0] xl_rx_restart,
  input wire logic [7:0] xl_sym_sent,
  input wire logic [7:0] xl_tok_sent,
  output logic [7:0] xl_tx_ready,
  output logic [7:0] st_enable,
  output logic [7:0] st_proc,
  output logic [39:0] st_chan
);

  // ****************************************
  // Register state
  // ****************************************
  logic [15:0] sw_div, next_sw_div;
  logic [15:0] ref_div, next_ref_div;
  logic [31:0] dir_lo, next_dir_lo;
  logic [31:0] dir_hi, next_dir_hi;
  logic [1:0] dbg_req_en, next_dbg_req_en;
  logic [1:0] dbg_drv_en, next_dbg_drv_en;
  logic [2:0] dbg_src, next_dbg_src;
  snr_pkg::snr_dir_t l_dir [`SNR_NLINK];
  snr_pkg::snr_dir_t next_l_dir [`SNR_NLINK];
  snr_pkg::snr_net_t l_net [`SNR_NLINK];
  snr_pkg::snr_net_t next_l_net [`SNR_NLINK];
  snr_pkg::snr_net_t p_net [`SNR_NLINK];
  snr_pkg::snr_net_t next_p_net [`SNR_NLINK];
  logic [7:0] x_en, next_x_en;
  logic [7:0] x_mode, next_x_mode;
  logic [7:0] x_err, next_x_err;
  snr_pkg::snr_gap_t x_sym [`SNR_NLINK];
  snr_pkg::snr_gap_t next_x_sym [`SNR_NLINK];
  snr_pkg::snr_gap_t x_tok [`SNR_NLINK];
  snr_pkg::snr_gap_t next_x_tok [`SNR_NLINK];
  logic [7:0] s_en, next_s_en;
  logic [7:0] s_proc, next_s_proc;
  snr_pkg::snr_chan_t s_chan [`SNR_NLINK];
  snr_pkg::snr_chan_t next_s_chan [`SNR_NLINK];
  logic [7:0] crrst_wr, rxrst_wr;
  logic [2:0] idx;
  logic wr;
  logic halt_evt;
  logic [2:0] evt_src;

  assign wr = cfg_req & cfg_write;
  assign idx = cfg_addr[2:0];

  // ****************************************
  // Register writes
  // ****************************************
  always_comb begin
    next_sw_div = sw_div;
    next_ref_div = ref_div;
    next_dir_lo = dir_lo;
    next_dir_hi = dir_hi;
    next_dbg_req_en = dbg_req_en;
    next_dbg_drv_en = dbg_drv_en;
    next_dbg_src = dbg_src;
    next_l_dir = l_dir;
    next_l_net = l_net;
    next_p_net = p_net;
    next_x_en = x_en;
    next_x_mode = x_mode;
    next_x_sym = x_sym;
    next_x_tok = x_tok;
    next_s_en = s_en;
    next_s_proc = s_proc;
    next_s_chan = s_chan;
    crrst_wr = 8'h00;
    rxrst_wr = 8'h00;
    if (wr) begin
      unique case (cfg_addr)
        `SNR_ADR_SWDIV: next_sw_div = cfg_wdata[15:0];
        `SNR_ADR_REFDIV: next_ref_div = cfg_wdata[15:0];
        `SNR_ADR_DIRLO: next_dir_lo = cfg_wdata;
        `SNR_ADR_DIRHI: next_dir_hi = cfg_wdata;
        `SNR_ADR_DBG0, `SNR_ADR_DBG1: begin
          next_dbg_req_en[cfg_addr[0]] = cfg_wdata[`SNR_B_DBG_REQ];
          next_dbg_drv_en[cfg_addr[0]] = cfg_wdata[`SNR_B_DBG_DRV];
        end
        `SNR_ADR_DBGSRC: next_dbg_src = {cfg_wdata[`SNR_B_SRC_PIN], cfg_wdata[1:0]};
        default: begin
          if (cfg_addr[7:3] == `SNR_ADR_LSTAT >> 3) begin
            next_l_dir[idx] = cfg_wdata[`SNR_L_DIR +: 4];
            next_l_net[idx] = cfg_wdata[`SNR_L_NET +: 2];
          end else if (cfg_addr[7:3] == `SNR_ADR_PSTAT >> 3) begin
            next_p_net[idx] = cfg_wdata[`SNR_L_NET +: 2];
          end else if (cfg_addr[7:3] == `SNR_ADR_XCFG >> 3) begin
            next_x_en[idx] = cfg_wdata[`SNR_B_XEN];
            next_x_mode[idx] = cfg_wdata[`SNR_B_XMODE];
            crrst_wr[idx] = cfg_wdata[`SNR_B_CRRST];
            rxrst_wr[idx] = cfg_wdata[`SNR_B_RXRST];
            next_x_sym[idx] = cfg_wdata[`SNR_L_SYMGAP +: 11];
            next_x_tok[idx] = cfg_wdata[`SNR_L_TOKGAP +: 11];
          end else if (cfg_addr[7:3] == `SNR_ADR_STATIC >> 3) begin
            next_s_en[idx] = cfg_wdata[`SNR_B_STEN];
            next_s_proc[idx] = cfg_wdata[`SNR_B_STPROC];
            next_s_chan[idx] = cfg_wdata[`SNR_L_STCHAN +: 5];
          end
        end
      endcase
    end
    if (halt_evt) begin
      next_dbg_src = evt_src;
    end
    next_x_err = (x_err & ~rxrst_wr) | xl_rx_overflow | xl_rx_illegal;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sw_div <= `SNR_RST_SWDIV;
      ref_div <= `SNR_RST_REFDIV;
      dir_lo <= 32'h0000_0000;
      dir_hi <= 32'h0000_0000;
      dbg_req_en <= 2'h0;
      dbg_drv_en <= 2'h0;
      dbg_src <= 3'h0;
      l_dir <= '{default: 4'h0};
      l_net <= '{default: 2'h0};
      p_net <= '{default: 2'h0};
      x_en <= 8'h00;
      x_mode <= 8'h00;
      x_err <= 8'h00;
      x_sym <= '{default: 11'h000};
      x_tok <= '{default: 11'h000};
      s_en <= 8'h00;
      s_proc <= 8'h00;
      s_chan <= '{default: 5'h00};
    end else begin
      sw_div <= next_sw_div;
      ref_div <= next_ref_div;
      dir_lo <= next_dir_lo;
      dir_hi <= next_dir_hi;
      dbg_req_en <= next_dbg_req_en;
      dbg_drv_en <= next_dbg_drv_en;
      dbg_src <= next_dbg_src;
      l_dir <= next_l_dir;
      l_net <= next_l_net;
      p_net <= next_p_net;
      x_en <= next_x_en;
      x_mode <= next_x_mode;
      x_err <= next_x_err;
      x_sym <= next_x_sym;
      x_tok <= next_x_tok;
      s_en <= next_s_en;
      s_proc <= next_s_proc;
      s_chan <= next_s_chan;
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (cfg_addr)
      `SNR_ADR_SWDIV: next_rdata[15:0] = sw_div;
      `SNR_ADR_REFDIV: next_rdata[15:0] = ref_div;
      `SNR_ADR_JTAGID: next_rdata = ID_CODE;
      `SNR_ADR_USER: next_rdata = {otp_user_code, metal_id_code};
      `SNR_ADR_DIRLO: next_rdata = dir_lo;
      `SNR_ADR_DIRHI: next_rdata = dir_hi;
      `SNR_ADR_DBG0, `SNR_ADR_DBG1: begin
        next_rdata[`SNR_B_DBG_REQ] = dbg_req_en[cfg_addr[0]];
        next_rdata[`SNR_B_DBG_DRV] = dbg_drv_en[cfg_addr[0]];
      end
      `SNR_ADR_DBGSRC: begin
        next_rdata[`SNR_B_SRC_PIN] = dbg_src[2];
        next_rdata[1:0] = dbg_src[1:0];
      end
      default: begin
        if (cfg_addr[7:3] == `SNR_ADR_LSTAT >> 3) begin
          next_rdata[`SNR_L_TARGET +: 2] = lnk_target[idx * 2 +: 2];
          next_rdata[`SNR_L_DEST +: 8] = lnk_dest[idx * 8 +: 8];
          next_rdata[`SNR_L_DIR +: 4] = l_dir[idx];
          next_rdata[`SNR_L_NET +: 2] = l_net[idx];
          next_rdata[`SNR_B_JUNK] = lnk_junk[idx];
          next_rdata[`SNR_B_DBUSY] = lnk_dst_busy[idx];
          next_rdata[`SNR_B_SBUSY] = lnk_src_busy[idx];
        end else if (cfg_addr[7:3] == `SNR_ADR_PSTAT >> 3) begin
          next_rdata[`SNR_L_TARGET +: 2] = plk_target[idx * 2 +: 2];
          next_rdata[`SNR_L_DEST +: 8] = plk_dest[idx * 8 +: 8];
          next_rdata[`SNR_L_NET +: 2] = p_net[idx];
          next_rdata[`SNR_B_JUNK] = plk_junk[idx];
          next_rdata[`SNR_B_DBUSY] = plk_dst_busy[idx];
          next_rdata[`SNR_B_SBUSY] = plk_src_busy[idx];
        end else if (cfg_addr[7:3] == `SNR_ADR_XCFG >> 3) begin
          next_rdata[`SNR_B_XEN] = x_en[idx];
          next_rdata[`SNR_B_XMODE] = x_mode[idx];
          next_rdata[`SNR_B_XERR] = x_err[idx];
          next_rdata[`SNR_B_CRGIVEN] = xl_credit_given[idx];
          next_rdata[`SNR_B_CRHELD] = xl_credit_held[idx];
          next_rdata[`SNR_L_SYMGAP +: 11] = x_sym[idx];
          next_rdata[`SNR_L_TOKGAP +: 11] = x_tok[idx];
        end else if (cfg_addr[7:3] == `SNR_ADR_STATIC >> 3) begin
          next_rdata[`SNR_B_STEN] = s_en[idx];
          next_rdata[`SNR_B_STPROC] = s_proc[idx];
          next_rdata[`SNR_L_STCHAN +: 5] = s_chan[idx];
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cfg_ack <= 1'b0;
      cfg_rdata <= 32'h0000_0000;
    end else begin
      cfg_ack <= cfg_req;
      cfg_rdata <= (cfg_req && !cfg_write) ? next_rdata : 32'h0000_0000;
    end
  end

  // ****************************************
  // Clock dividers
  // ****************************************
  logic [15:0] sw_cnt, next_sw_cnt;
  logic [15:0] ref_cnt, next_ref_cnt;

  always_comb begin
    next_sw_cnt = (sw_cnt >= sw_div) ? 16'h0000 : sw_cnt + 16'h0001;
    next_ref_cnt = (ref_cnt >= ref_div) ? 16'h0000 : ref_cnt + 16'h0001;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sw_cnt <= 16'h0000;
      ref_cnt <= 16'h0000;
      sw_clk_en <= 1'b0;
      ref_clk_en <= 1'b0;
    end else begin
      sw_cnt <= next_sw_cnt;
      ref_cnt <= next_ref_cnt;
      sw_clk_en <= (sw_cnt >= sw_div);
      ref_clk_en <= (ref_cnt >= ref_div);
    end
  end

  // ****************************************
  // Route lookup
  // ****************************************
  logic [3:0] next_route_dir;
  logic [15:0] diff;
  logic [31:0] dir_word;
  logic [7:0] diff_byte;

  always_comb begin
    diff = node_id ^ route_dest;
    next_route_dir = 4'h0;
    dir_word = (diff[15:8] != 8'h00) ? dir_hi : dir_lo;
    diff_byte = (diff[15:8] != 8'h00) ? diff[15:8] : diff[7:0];
    for (int i = 0; i < 8; i++) begin
      if (diff_byte[i]) begin
        next_route_dir = dir_word[i * 4 +: 4];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      route_valid <= 1'b0;
      route_dir <= 4'h0;
    end else begin
      route_valid <= route_req;
      route_dir <= route_req ? next_route_dir : route_dir;
    end
  end

  // ****************************************
  // Shared halt line
  // ****************************************
  logic [1:0] drv;
  logic line_now, line_prev;

  always_comb begin
    drv = core_halted_flag & dbg_drv_en;
    line_now = (|drv) | ~halt_pin_in_n;
    halt_evt = line_now & ~line_prev;
    evt_src = {~halt_pin_in_n & halt_pin_oe_n, drv};
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      line_prev <= 1'b0;
      halt_pin_oe_n <= 1'b1;
      shared_halt_line <= 1'b0;
      halt_request <= 2'h0;
    end else begin
      line_prev <= line_now;
      halt_pin_oe_n <= ~(|drv);
      shared_halt_line <= line_now;
      halt_request <= {2{line_now}} & dbg_req_en;
    end
  end

  assign halt_pin_out = 1'b0;

  // ****************************************
  // External link control
  // ****************************************
  snr_pkg::snr_gcnt_t gap [`SNR_NLINK];
  snr_pkg::snr_gcnt_t next_gap [`SNR_NLINK];

  always_comb begin
    for (int i = 0; i < `SNR_NLINK; i++) begin
      next_gap[i] = gap[i];
      if (xl_tok_sent[i]) begin
        next_gap[i] = {1'b0, x_tok[i]} + 12'h001;
      end else if (xl_sym_sent[i]) begin
        next_gap[i] = {1'b0, x_sym[i]} + 12'h001;
      end else if (gap[i] != 12'h000) begin
        next_gap[i] = gap[i] - 12'h001;
      end
      xl_tx_ready[i] = x_en[i] && gap[i] == 12'h000;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      gap <= '{default: 12'h000};
      xl_credit_clear <= 8'h00;
      xl_hello_req <= 8'h00;
      xl_rx_restart <= 8'h00;
    end else begin
      gap <= next_gap;
      xl_credit_clear <= crrst_wr;
      xl_hello_req <= crrst_wr;
      xl_rx_restart <= rxrst_wr;
    end
  end

  // ****************************************
  // Field outputs
  // ****************************************
  always_comb begin
    for (int i = 0; i < `SNR_NLINK; i++) begin
      lnk_dir[i * 4 +: 4] = l_dir[i];
      lnk_net[i * 2 +: 2] = l_net[i];
      plk_net[i * 2 +: 2] = p_net[i];
      st_chan[i * 5 +: 5] = s_chan[i];
    end
  end

  assign xl_enable = x_en;
  assign xl_five_wire = x_mode;
  assign st_enable = s_en;
  assign st_proc = s_proc;

endmodule : snr_top

// File: verif/snr_far_model.sv
`timescale 1ns/100ps
module snr_far_model (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic slow,
  input wire logic [7:0] err_ovf,
  input wire logic [7:0] err_ill,
  input wire logic [7:0] xl_enable,
  input wire logic [7:0] xl_hello_req,
  input wire logic [7:0] xl_tx_ready,
  output logic [7:0] xl_rx_overflow,
  output logic [7:0] xl_rx_illegal,
  output logic [7:0] xl_credit_given,
  output logic [7:0] xl_credit_held,
  output logic [7:0] xl_sym_sent,
  output logic [7:0] xl_tok_sent
);
  // ****
  // Remote end of the serial links
  // ****
  logic [2:0] tick;
  logic ph;
  logic [7:0] go;
  assign go = xl_tx_ready & xl_credit_held & ~xl_tok_sent & ~xl_sym_sent;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      {tick, ph, xl_rx_overflow, xl_rx_illegal} <= '0;
      {xl_credit_given, xl_credit_held, xl_sym_sent, xl_tok_sent} <= '0;
    end else begin
      tick <= tick + 3'h1;
      ph <= ~ph;
      xl_rx_overflow <= err_ovf;
      xl_rx_illegal <= err_ill;
      xl_credit_given <= xl_enable;
      xl_credit_held <= (xl_credit_held | (xl_enable & {8{!slow || tick == 3'h0}})) & ~xl_hello_req;
      xl_tok_sent <= go & {8{ph}};
      xl_sym_sent <= go & {8{!ph}};
    end
  end
endmodule : snr_far_model

// File: verif/snr_top_chk.sv
`timescale 1ns/100ps
module snr_top_chk (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic cfg_req,
  input wire logic cfg_write,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic cfg_ack,
  input wire logic [15:0] node_id,
  input wire logic route_req,
  input wire logic [15:0] route_dest,
  input wire logic route_valid,
  input wire logic [3:0] route_dir,
  input wire logic [1:0] halt_request,
  input wire logic halt_pin_oe_n,
  input wire logic shared_halt_line,
  input wire logic [7:0] xl_hello_req,
  input wire logic [7:0] xl_credit_clear,
  input wire logic [7:0] xl_rx_restart,
  input wire logic [7:0] xl_sym_sent,
  input wire logic [7:0] xl_tok_sent,
  input wire logic [7:0] xl_tx_ready
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ****
  // Properties
  // ****
  property p_ack;
    cfg_req |=> cfg_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("config ack missing");
  property p_route;
    route_req |=> route_valid;
  endproperty
  a_route: assert property (p_route) else $error("route result missing");
  property p_route_eq;
    route_req && route_dest == node_id |=> route_dir == 4'h0;
  endproperty
  a_route_eq: assert property (p_route_eq) else $error("equal id not direction zero");
  property p_hello;
    logic [2:0] n;
    (cfg_req && cfg_write && cfg_addr[7:3] == 5'h10 && cfg_wdata[24], n = cfg_addr[2:0])
      |=> xl_hello_req[n] && xl_credit_clear[n];
  endproperty
  a_hello: assert property (p_hello) else $error("credit reset pulse missing");
  property p_rxrst;
    logic [2:0] n;
    (cfg_req && cfg_write && cfg_addr[7:3] == 5'h10 && cfg_wdata[23], n = cfg_addr[2:0]) |=> xl_rx_restart[n];
  endproperty
  a_rxrst: assert property (p_rxrst) else $error("receiver restart missing");
  property p_halt_req;
    halt_request != 2'b00 |-> shared_halt_line;
  endproperty
  a_halt_req: assert property (p_halt_req) else $error("halt request without line");
  property p_oe;
    !halt_pin_oe_n |-> shared_halt_line;
  endproperty
  a_oe: assert property (p_oe) else $error("pin driven without line");
  property p_gap;
    (xl_tok_sent | xl_sym_sent) != 8'h00 |=> (xl_tx_ready & ($past(xl_tok_sent) | $past(xl_sym_sent))) == 8'h00;
  endproperty
  a_gap: assert property (p_gap) else $error("ready right after send");
  c_hello: cover property (xl_hello_req != 8'h00);
  c_route: cover property (route_valid && route_dir != 4'h0);
  c_pin: cover property (!halt_pin_oe_n);
endmodule : snr_top_chk
bind snr_top snr_top_chk u_chk (.*);

// File: verif/switch_node_link_routing_control_test.sv
`timescale 1ns/100ps
module switch_node_link_routing_control_test;
  localparam logic [31:0] ID = 32'hA5C3_0F11; // Arbitrary value
  localparam logic [7:0] RA [6] = '{8'h07, 8'h08, 8'h0C, 8'h0D, 8'h10, 8'h11};
  localparam logic [31:0] RM [6] = '{32'hFFFF, 32'hFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h3, 32'h3};
  logic clk_sys = 0, nrst = 0, cfg_req = 0, cfg_write = 0, route_req = 0, slow = 0, ext_n = 1;
  logic cfg_ack, sw_clk_en, ref_clk_en, route_valid, halt_pin_in_n, halt_pin_out, halt_pin_oe_n, shared_halt_line;
  logic [7:0] cfg_addr = 0, err_ovf = 0, err_ill = 0, lnk_junk = 0, lnk_dst_busy = 0, lnk_src_busy = 0;
  logic [7:0] plk_junk = 0, plk_dst_busy = 0, plk_src_busy = 0, xl_enable, xl_five_wire, xl_rx_overflow;
  logic [7:0] xl_rx_illegal, xl_credit_given, xl_credit_held, xl_credit_clear, xl_hello_req, xl_rx_restart;
  logic [7:0] xl_sym_sent, xl_tok_sent, xl_tx_ready, st_enable, st_proc;
  logic [31:0] cfg_wdata = 0, cfg_rdata, rd, lnk_dir, v, w;
  logic [15:0] node_id = 0, route_dest = 0, lnk_target = 0, plk_target = 0, lnk_net, plk_net, snap;
  logic [13:0] otp_user_code = 0;
  logic [17:0] metal_id_code = 0;
  logic [3:0] route_dir;
  logic [1:0] core_halted_flag = 0, halt_request;
  logic [63:0] lnk_dest = 0, plk_dest = 0, tbl;
  logic [39:0] st_chan;
  int err_count = 0, n_checks = 0, cyc = 0;
  assign halt_pin_in_n = ext_n & (halt_pin_oe_n | halt_pin_out);
  snr_top #(.ID_CODE(ID)) u_dut (.*);
  snr_far_model u_far (.*);
  always #50 clk_sys = ~clk_sys;
  // ****
  // Tasks
  // ****
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic cfg(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    {cfg_req, cfg_write, cfg_addr, cfg_wdata} = {1'b1, wr, a, d};
    snap = {xl_credit_given, xl_credit_held};
    @(negedge clk_sys);
    cfg_req = 0;
    rd = cfg_rdata;
    chk("ack", 1, cfg_ack);
  endtask : cfg
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    cfg(0, a, 0);
    chk(what, exp, rd);
  endtask : rdchk
  task automatic xrd(input int n, input logic [31:0] x, input logic e);
    cfg(0, 8'(8'h80 + n), 0);
    chk("xcfg", {x[31:30], 2'h0, e, snap[8 + n], snap[n], 3'h0, x[21:0]}, rd & 32'hFE7FFFFF);
  endtask : xrd
  function automatic logic [3:0] exp_dir(input logic [15:0] x, input logic [63:0] t);
    for (int k = 15; k >= 0; k--) begin
      if (x[k]) return t[k * 4 +: 4];
    end
    return 4'h0;
  endfunction : exp_dir
  // ****
  // Main sequence
  // ****
  initial begin
    void'($urandom(8));
    otp_user_code = 14'($urandom);
    metal_id_code = 18'($urandom);
    node_id = 16'($urandom);
    repeat (5) @(negedge clk_sys);
    nrst = 1;
    {v, w} = '0;
    repeat (60) begin
      @(negedge clk_sys);
      v += 32'(sw_clk_en);
      w += 32'(ref_clk_en);
    end
    chk("swclk", 60, v);
    chk("refclk", 15, w);
    for (int i = 0; i < 6; i++) begin
      rdchk("rst", RA[i], (i == 1) ? 32'h3 : 32'h0);
      v = $urandom;
      cfg(1, RA[i], v);
      rdchk("rw", RA[i], v & RM[i]);
    end
    cfg(1, 8'h0A, 32'hFFFFFFFF);
    rdchk("user", 8'h0A, {otp_user_code, metal_id_code});
    rdchk("id", 8'h09, ID);
    rdchk("none", 8'h28, 0);
    $display("registers done");
    tbl = {$urandom, $urandom};
    cfg(1, 8'h0C, tbl[31:0]);
    cfg(1, 8'h0D, tbl[63:32]);
    for (int i = 0; i < 40; i++) begin
      @(negedge clk_sys);
      route_req = 1;
      route_dest = (i < 17) ? node_id ^ 16'((17'h1 << i) >> 1) : 16'($urandom);
      @(negedge clk_sys);
      route_req = 0;
      chk("rvalid", 1, route_valid);
      chk("rdir", exp_dir(route_dest ^ node_id, tbl), route_dir);
    end
    $display("routing done");
    {lnk_target, plk_target} = $urandom;
    {lnk_dest, plk_dest} = {$urandom, $urandom, $urandom, $urandom};
    {lnk_junk, lnk_dst_busy, lnk_src_busy, plk_junk} = $urandom;
    {plk_dst_busy, plk_src_busy} = 16'($urandom);
    for (int n = 0; n < 8; n++) begin
      v = $urandom;
      cfg(1, 8'(8'h20 + n), v);
      rdchk("lstat", 8'(8'h20 + n), {6'h0, lnk_target[2 * n +: 2], lnk_dest[8 * n +: 8], 4'h0, v[11:8], 2'h0,
        v[5:4], 1'b0, lnk_junk[n], lnk_dst_busy[n], lnk_src_busy[n]});
      chk("lout", {v[5:4], v[11:8]}, {lnk_net[2 * n +: 2], lnk_dir[4 * n +: 4]});
      cfg(1, 8'(8'h40 + n), v);
      rdchk("pstat", 8'(8'h40 + n), {6'h0, plk_target[2 * n +: 2], plk_dest[8 * n +: 8], 10'h0, v[5:4], 1'b0,
        plk_junk[n], plk_dst_busy[n], plk_src_busy[n]});
      chk("pout", v[5:4], plk_net[2 * n +: 2]);
    end
    $display("link status done");
    for (int n = 0; n < 8; n++) begin
      slow = (n >= 4);
      v = $urandom | 32'h0180_0000;
      cfg(1, 8'(8'h80 + n), v);
      chk("xout", v[31:30], {xl_enable[n], xl_five_wire[n]});
      xrd(n, v, 0);
      @(negedge clk_sys);
      if (n[0]) err_ill[n] = 1;
      else err_ovf[n] = 1;
      @(negedge clk_sys);
      {err_ovf, err_ill} = '0;
      xrd(n, v, 1);
      v = (v & 32'hFE7FFFFF) | 32'h0080_0000;
      cfg(1, 8'(8'h80 + n), v);
      xrd(n, v, 0);
    end
    slow = 0;
    cfg(1, 8'h80, 32'h8000_1005);
    w = 0;
    while (!xl_tok_sent[0] && w < 5000) begin
      @(negedge clk_sys);
      w++;
    end
    chk("tokwait", 1, w < 5000);
    v = 0;
    @(negedge clk_sys);
    while (!xl_tx_ready[0] && v < 50) begin
      v++;
      @(negedge clk_sys);
    end
    chk("tokgap", 6, v);
    $display("link setup done");
    cfg(1, 8'h10, 32'h3);
    cfg(1, 8'h11, 32'h2);
    core_halted_flag = 2'b10;
    repeat (2) @(negedge clk_sys);
    chk("nodrv", 4'b0100, {shared_halt_line, halt_pin_oe_n, halt_request});
    core_halted_flag = 2'b01;
    repeat (2) @(negedge clk_sys);
    chk("drv", 4'b1011, {shared_halt_line, halt_pin_oe_n, halt_request});
    rdchk("src", 8'h1F, 32'h01);
    core_halted_flag = 2'b00;
    repeat (2) @(negedge clk_sys);
    ext_n = 0;
    repeat (2) @(negedge clk_sys);
    chk("pin", 4'b1111, {shared_halt_line, halt_pin_oe_n, halt_request});
    rdchk("src", 8'h1F, 32'h10);
    ext_n = 1;
    cfg(1, 8'h11, 32'h3);
    core_halted_flag = 2'b10;
    repeat (2) @(negedge clk_sys);
    rdchk("src1", 8'h1F, 32'h02);
    core_halted_flag = 2'b00;
    cfg(1, 8'hA3, 32'h8000_0115);
    chk("static", 7'h75, {st_enable[3], st_proc[3], st_chan[15 +: 5]});
    $display("halt and static done");
    complete_run();
  end
endmodule : switch_node_link_routing_control_test
